/* sbw_pkg.sv */
package sbw_pkg;
    localparam int          ADDR_W       = 6;
    localparam int          DATA_W       = 32;
    // Register byte offsets
    localparam logic [5:0]  OFS_BAUD     = 6'h00;
    localparam logic [5:0]  OFS_SFINE    = 6'h04;
    localparam logic [5:0]  OFS_RFINE    = 6'h08;
    localparam logic [5:0]  OFS_CTRL     = 6'h0C;
    localparam logic [5:0]  OFS_RDATA    = 6'h10;
    localparam logic [5:0]  OFS_IRQ_STAT = 6'h14;
    localparam logic [5:0]  OFS_IRQ_CLR  = 6'h18;
    localparam logic [5:0]  OFS_IRQ_EN   = 6'h1C;
    // baud_rate_register fields
    localparam int          BAUD_CS_LSB  = 6;
    localparam int          BAUD_SS_LSB  = 3;
    localparam int          BAUD_RS_LSB  = 0;
    // Control register fields
    localparam int          CTRL_TX_EN   = 0;
    localparam int          CTRL_RX_EN   = 1;
    localparam int          CTRL_MUTE    = 2;
    localparam int          CTRL_WAKE    = 3;
    // Event bit positions (status, clear and enable share the layout)
    localparam int          EV_RDF       = 0;
    localparam int          EV_IDLE      = 1;
    localparam int          EV_WAKE      = 2;
    localparam int          EV_N         = 3;
    // Reset values
    localparam logic [7:0]  RST_BAUD     = 8'h00;
    localparam logic [7:0]  RST_FINE     = 8'h00;
    localparam logic [3:0]  RST_CTRL     = 4'h0;
    // Divider constants
    localparam int          OVERSAMPLE   = 16;
    localparam int          PER_W        = 19;
    localparam logic [3:0]  COARSE_1     = 4'h1;
    localparam logic [3:0]  COARSE_3     = 4'h3;
    localparam logic [3:0]  COARSE_4     = 4'h4;
    localparam logic [3:0]  COARSE_13    = 4'hD;
    localparam int          CHAR_W       = 9;

    typedef enum logic [1:0] {
        SBW_BUS_IDLE = 2'b01,
        SBW_BUS_ACK  = 2'b10
    } sbw_bus_e;
endpackage

/* sbw_serial_baud_and_wakeup.sv */
// What this block does
// - Separate send and receive rates, divided by 16
// - Coarse select picks 1, 3, 4 or 13
// - Send select picks power-of-two ratio to 128
// - Receive select picks independent power-of-two ratio
// - Fine prescaler divides further by 1..255
// - Fine value zero leaves conventional rate
// - Fine rate is clock/16/fine/coarse/ratio
// - Muted receiver sets no flags but wake (and data full on address wake)
// - Wake method bit: idle or address mark
// - Idle wake clears mute, no idle flag
// - Address wake clears mute, sets data full
`timescale 1ns/100ps
`default_nettype none
module sbw_serial_baud_and_wakeup
#(
    parameter int unsigned CLK_HZ = 125000000
)
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    input  wire logic [sbw_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [sbw_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [sbw_pkg::DATA_W-1:0]  avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        rx_char_valid,
    input  wire logic [sbw_pkg::CHAR_W-1:0]  rx_char_data,
    input  wire logic                        rx_char_msb,
    input  wire logic                        rx_idle_frame,
    output logic                             tx_sample_tick,
    output logic                             tx_bit_tick,
    output logic                             rx_sample_tick,
    output logic                             rx_bit_tick,
    output logic                             tx_enable,
    output logic                             rx_enable,
    output logic                             receiver_mute,
    output logic                             irq
);
    import sbw_pkg::*;

    logic [7:0]             baud_rate_register;
    logic [7:0]             send_fine_register;
    logic [7:0]             receive_fine_register;
    logic                   wake_method;
    logic [CHAR_W-1:0]      rx_data;
    logic [EV_N-1:0]        irq_status;
    logic [EV_N-1:0]        irq_enable;
    sbw_bus_e               bus_state;
    logic                   acc;
    logic                   wr_hit;
    logic                   rd_hit;
    logic                   wr_lo;
    logic [DATA_W-1:0]      next_readdata;
    logic [1:0]             coarse_divisor_select;
    logic [2:0]             send_divisor_select;
    logic [2:0]             receive_divisor_select;
    logic [3:0]             coarse_divisor;
    logic [1:0]             dir_en;
    logic                   dir_sample [2];
    logic                   dir_bit    [2];
    logic [2:0]             dir_sel   [2];
    logic [7:0]             dir_fine  [2];
    logic                   wake_idle;
    logic                   wake_addr;
    logic                   rx_accept;
    logic [EV_N-1:0]        ev_set;
    logic [EV_N-1:0]        ev_clr;

    // Bus slave: every access answers after one wait cycle
    // A frozen slave keeps waitrequest high so no write is dropped
    assign acc             = avs_read | avs_write;
    assign avs_waitrequest = acc & (~ce | (bus_state != SBW_BUS_ACK));
    assign wr_hit          = ce & avs_write & (bus_state == SBW_BUS_ACK);
    assign rd_hit          = ce & avs_read & (bus_state == SBW_BUS_ACK);
    assign wr_lo           = wr_hit & avs_byteenable[0];

    // Two-state answer sequencer; ce low parks it where it is
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            bus_state <= SBW_BUS_IDLE;
        else if (ce)
        begin
            unique case (bus_state)
                SBW_BUS_IDLE:
                begin
                    if (acc)
                        bus_state <= SBW_BUS_ACK;
                end
                SBW_BUS_ACK:
                    bus_state <= SBW_BUS_IDLE;
            endcase
        end
    end

    always_comb
    begin
        next_readdata = '0;
        unique case (avs_address)
            OFS_BAUD:     next_readdata[7:0] = baud_rate_register;
            OFS_SFINE:    next_readdata[7:0] = send_fine_register;
            OFS_RFINE:    next_readdata[7:0] = receive_fine_register;
            OFS_CTRL:
            begin
                next_readdata[CTRL_TX_EN] = tx_enable;
                next_readdata[CTRL_RX_EN] = rx_enable;
                next_readdata[CTRL_MUTE]  = receiver_mute;
                next_readdata[CTRL_WAKE]  = wake_method;
            end
            OFS_RDATA:    next_readdata[CHAR_W-1:0] = rx_data;
            OFS_IRQ_STAT: next_readdata[EV_N-1:0]   = irq_status;
            OFS_IRQ_EN:   next_readdata[EV_N-1:0]   = irq_enable;
            // Clear register is write-only; unmapped reads give zero
            default:      next_readdata = '0;
        endcase
    end

    // Captured in the first cycle so the data stand at the answer edge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            avs_readdata <= '0;
        else if (ce && avs_read && bus_state == SBW_BUS_IDLE)
            avs_readdata <= next_readdata;
    end

    // Divisor registers; changing them while enabled is the software's hazard
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            baud_rate_register <= RST_BAUD;
        else if (wr_lo && avs_address == OFS_BAUD)
            baud_rate_register <= avs_writedata[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            send_fine_register <= RST_FINE;
        else if (wr_lo && avs_address == OFS_SFINE)
            send_fine_register <= avs_writedata[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            receive_fine_register <= RST_FINE;
        else if (wr_lo && avs_address == OFS_RFINE)
            receive_fine_register <= avs_writedata[7:0];
    end

    // Control bits; mute lives apart because hardware also clears it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tx_enable <= RST_CTRL[CTRL_TX_EN];
        else if (wr_lo && avs_address == OFS_CTRL)
            tx_enable <= avs_writedata[CTRL_TX_EN];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rx_enable <= RST_CTRL[CTRL_RX_EN];
        else if (wr_lo && avs_address == OFS_CTRL)
            rx_enable <= avs_writedata[CTRL_RX_EN];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wake_method <= RST_CTRL[CTRL_WAKE];
        else if (wr_lo && avs_address == OFS_CTRL)
            wake_method <= avs_writedata[CTRL_WAKE];
    end

    // One baud register feeds both directions' selects
    assign coarse_divisor_select  = baud_rate_register[BAUD_CS_LSB +: 2];
    assign send_divisor_select    = baud_rate_register[BAUD_SS_LSB +: 3];
    assign receive_divisor_select = baud_rate_register[BAUD_RS_LSB +: 3];

    always_comb
    begin
        unique case (coarse_divisor_select)
            2'h0: coarse_divisor = COARSE_1;
            2'h1: coarse_divisor = COARSE_3;
            2'h2: coarse_divisor = COARSE_4;
            2'h3: coarse_divisor = COARSE_13;
        endcase
    end

    assign dir_sel[0]  = send_divisor_select;
    assign dir_sel[1]  = receive_divisor_select;
    assign dir_fine[0] = send_fine_register;
    assign dir_fine[1] = receive_fine_register;
    assign dir_en      = {rx_enable, tx_enable};

    // one divider chain per direction, enable pulses only
    for (genvar d = 0; d < 2; d++)
    begin : g_chain
        logic [PER_W-1:0] period;
        logic [PER_W-1:0] pre_cnt;
        logic [3:0]       os_cnt;
        logic [7:0]       fine_eff;
        logic [11:0]      pre_prod;
        logic             pre_hit;

        // zero fine value bypasses the fine prescaler
        assign fine_eff = (dir_fine[d] == 8'h00) ? 8'h01 : dir_fine[d];
        // fine factor joins the prescale product
        assign pre_prod = 12'(fine_eff) * 12'(coarse_divisor);
        // fine times coarse times power-of-two ratio
        assign period   = PER_W'({7'h00, pre_prod} << dir_sel[d]);
        // Prescale wrap marks the end of one sample period
        assign pre_hit  = dir_en[d] & (pre_cnt >= period - PER_W'(1));

        always_ff @(posedge clk)
        begin
            if (!rst_n)
                pre_cnt <= '0;
            else if (ce)
            begin
                if (!dir_en[d] || pre_hit)
                    pre_cnt <= '0;
                else
                    pre_cnt <= pre_cnt + PER_W'(1);
            end
        end

        // bit rate is sample rate over 16
        always_ff @(posedge clk)
        begin
            if (!rst_n)
                os_cnt <= '0;
            else if (ce)
            begin
                if (!dir_en[d])
                    os_cnt <= '0;
                else if (pre_hit)
                    os_cnt <= os_cnt + 4'h1;
            end
        end

        // Registered enables, so no logic runs on a derived clock
        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                dir_sample[d] <= 1'b0;
                dir_bit[d]    <= 1'b0;
            end
            else if (ce)
            begin
                dir_sample[d] <= pre_hit;
                dir_bit[d]    <= pre_hit & (os_cnt == 4'(OVERSAMPLE - 1));
            end
        end
    end

    // Tick outputs are the chain registers themselves
    assign tx_sample_tick = dir_sample[0];
    assign rx_sample_tick = dir_sample[1];
    assign tx_bit_tick    = dir_bit[0];
    assign rx_bit_tick    = dir_bit[1];

    // wake method picks the wake source
    // idle frame wakes, without flagging idle
    assign wake_idle = receiver_mute & ~wake_method & rx_idle_frame;
    // address mark word wakes and is kept
    assign wake_addr = receiver_mute & wake_method & rx_char_valid & rx_char_msb;
    // muted receiver accepts nothing but the waking word
    assign rx_accept = rx_char_valid & (~receiver_mute | wake_addr);

    // Software write wins over a same-cycle hardware wake
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            receiver_mute <= RST_CTRL[CTRL_MUTE];
        else if (wr_lo && avs_address == OFS_CTRL)
            receiver_mute <= avs_writedata[CTRL_MUTE];
        else if (ce && (wake_idle || wake_addr))
            receiver_mute <= 1'b0;
    end

    // Kept word holds until the next accepted one; no overrun tracking
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rx_data <= '0;
        else if (ce && rx_accept)
            rx_data <= rx_char_data;
    end

    // no event while muted, except the wake flag and the address wake's data full
    always_comb
    begin
        ev_set          = '0;
        ev_set[EV_RDF]  = rx_accept;
        ev_set[EV_IDLE] = rx_idle_frame & ~receiver_mute;
        ev_set[EV_WAKE] = wake_idle | wake_addr;
    end

    // Reading the received word retires its full flag
    always_comb
    begin
        ev_clr = '0;
        if (wr_lo && avs_address == OFS_IRQ_CLR)
            ev_clr = avs_writedata[EV_N-1:0];
        if (rd_hit && avs_address == OFS_RDATA)
            ev_clr[EV_RDF] = 1'b1;
    end

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_status <= '0;
        else if (ce)
            irq_status <= (irq_status & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_enable <= '0;
        else if (wr_lo && avs_address == OFS_IRQ_EN)
            irq_enable <= avs_writedata[EV_N-1:0];
    end

    // Level interrupt: any enabled sticky event
    assign irq = |(irq_status & irq_enable);
endmodule
`default_nettype wire

/* sbw_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module sbw_monitor
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [5:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic       avs_waitrequest,
    input  wire logic       rx_char_valid,
    input  wire logic       rx_char_msb,
    input  wire logic       rx_idle_frame,
    input  wire logic       tx_sample_tick,
    input  wire logic       tx_bit_tick,
    input  wire logic       rx_sample_tick,
    input  wire logic       rx_bit_tick,
    input  wire logic       tx_enable,
    input  wire logic       receiver_mute
);
    import sbw_pkg::*;
    logic [4:0] tx_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Sample ticks seen since the last bit tick
    always_ff @(posedge clk)
        if (!rst_n || !tx_enable || tx_bit_tick)
            tx_cnt <= 5'h00;
        else if (tx_sample_tick)
            tx_cnt <= tx_cnt + 5'h01;
    AST_TX_BIT_SYNC:
        assert property (tx_bit_tick |-> tx_sample_tick) else $error("tx bit tick alone");
    AST_RX_BIT_SYNC:
        assert property (rx_bit_tick |-> rx_sample_tick) else $error("rx bit tick alone");
    AST_TX_BIT16:
        assert property (tx_bit_tick |-> tx_cnt == 5'h0F) else $error("tx bit tick not 16th");
    AST_TX_QUIET:
        assert property (!tx_enable && !$past(tx_enable) |-> !tx_sample_tick && !tx_bit_tick)
        else $error("tx tick while disabled");
    AST_WAIT_ONE:
        assert property (($rose(avs_read) || $rose(avs_write)) && ce
            |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait not one cycle");
    AST_MUTE_FALL:
        assert property ($fell(receiver_mute) && !$past(avs_write) |-> $past(rx_idle_frame)
            || ($past(rx_char_valid) && $past(rx_char_msb))) else $error("mute cleared uncaused");
    AST_MUTE_RISE:
        assert property ($rose(receiver_mute) |-> $past(avs_write) && !$past(avs_waitrequest)
            && $past(avs_address) == OFS_CTRL) else $error("mute set without write");
    AST_TX_EN_SRC:
        assert property ($changed(tx_enable) |-> $past(avs_write) && $past(avs_address) == OFS_CTRL)
        else $error("tx enable changed without write");
endmodule
bind sbw_serial_baud_and_wakeup sbw_monitor sbw_monitor_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .rx_char_valid(rx_char_valid), .rx_char_msb(rx_char_msb),
    .rx_idle_frame(rx_idle_frame), .tx_sample_tick(tx_sample_tick), .tx_bit_tick(tx_bit_tick),
    .rx_sample_tick(rx_sample_tick), .rx_bit_tick(rx_bit_tick), .tx_enable(tx_enable),
    .receiver_mute(receiver_mute));
`default_nettype wire

/* sbw_node_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sbw_node_model
(
    input  wire logic       clk,
    output logic            rx_char_valid,
    output logic [8:0]      rx_char_data,
    output logic            rx_char_msb,
    output logic            rx_idle_frame
);
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char_data = 9'h000;
        rx_char_msb = 1'b0;
        rx_idle_frame = 1'b0;
    end
    // address mark rides as the word's top bit
    task automatic send(input logic [8:0] d, input logic idle, input int gap);
        repeat (gap) @(posedge clk);
        rx_char_valid <= !idle;
        rx_idle_frame <= idle;
        rx_char_data <= d;
        rx_char_msb <= d[8];
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rx_idle_frame <= 1'b0;
        // Stale word inverted so it is never read as fresh
        rx_char_data <= ~d;
        rx_char_msb <= ~d[8];
    endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sbw_pkg::*;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic        rxv, rxm, rxi, txs, txb, rxs, rxb, tx_en, rx_en, mute;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [8:0]  rxd;
    logic        ce, cep = 1'b1;
    logic [3:0]  be;
    int          tsc = 0, rsc = 0;
    logic [31:0] rq[$];
    int          tq[$], pq[$];
    int          error_cnt = 0, checks = 0, cyc = 0, tlast = 0, rlast = 0;
    logic [15:0] lf = 16'h0001;
    logic [7:0]  b, tf, rf;
    logic [7:0]  bt[4] = '{8'h00, 8'hC7, 8'h79, 8'h9A};
    logic [7:0]  tt[4] = '{8'h00, 8'hFF, 8'h00, 8'h02};
    logic [7:0]  rt[4] = '{8'h00, 8'h00, 8'h01, 8'h03};
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    sbw_serial_baud_and_wakeup sbw_serial_baud_and_wakeup_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_char_valid(rxv), .rx_char_data(rxd),
        .rx_char_msb(rxm), .rx_idle_frame(rxi), .tx_sample_tick(txs), .tx_bit_tick(txb),
        .rx_sample_tick(rxs), .rx_bit_tick(rxb), .tx_enable(tx_en), .rx_enable(rx_en),
        .receiver_mute(mute), .irq(irq));
    sbw_node_model sbw_node_model_i (.clk(clk), .rx_char_valid(rxv), .rx_char_data(rxd),
        .rx_char_msb(rxm), .rx_idle_frame(rxi));
    task automatic summarize();
        $display("errors=%0d checks=%0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    function automatic int per(logic [7:0] bd, logic [2:0] s, logic [7:0] f);
        int k;
        k = (bd[7:6] == 2'h0) ? 1 : (bd[7:6] == 2'h1) ? 3 : (bd[7:6] == 2'h2) ? 4 : 13;
        return ((f == 8'h00) ? 1 : int'(f)) * k * (1 << s);
    endfunction
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    always @(posedge clk)
    begin
        cyc++;
        if (avs_read && avs_waitrequest === 1'b0)
            chk(rq.pop_front(), avs_readdata);
        // Ticks only count when the edge that made them was not frozen
        if (cep === 1'b1)
        begin
            if (txs === 1'b1)
            begin
                if (tq.size() > 0)
                    chk(tq.pop_front(), cyc - tlast);
                tlast = cyc;
            end
            if (rxs === 1'b1)
            begin
                if (pq.size() > 0)
                    chk(pq.pop_front(), cyc - rlast);
                rlast = cyc;
            end
            if (txb === 1'b1)
                chk(32'h10, tsc + 1);
            if (rxb === 1'b1)
                chk(32'h10, rsc + 1);
            tsc = (tx_en !== 1'b1 || txb === 1'b1) ? 0 : tsc + int'(txs === 1'b1);
            rsc = (rx_en !== 1'b1 || rxb === 1'b1) ? 0 : rsc + int'(rxs === 1'b1);
        end
        cep = ce;
        if (cyc == 60000)
        begin
            error_cnt++;
            summarize();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        ce = 1'b1;
        be = 4'hF;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, then the unmapped hole at 0x20
        for (int a = 0; a <= 32; a += 4)
            rd(a[5:0], 32'h0);
        // Lane 0 off: the write is refused
        be <= 4'hE;
        bus(1'b1, OFS_IRQ_EN, 32'h7);
        be <= 4'hF;
        rd(OFS_IRQ_EN, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            lf = lfsr(lf);
            b = (i < 4) ? bt[i] : lf[7:0] & 8'hDB;
            tf = (i < 4) ? tt[i] : {5'h00, lf[10:8]};
            rf = (i < 4) ? rt[i] : {5'h00, lf[13:11]};
            // divisors are touched only while both directions are off
            bus(1'b1, OFS_CTRL, 32'h0);
            bus(1'b1, OFS_BAUD, {24'h0, b});
            bus(1'b1, OFS_SFINE, {24'h0, tf});
            bus(1'b1, OFS_RFINE, {24'h0, rf});
            rd(OFS_BAUD, {24'h0, b});
            bus(1'b1, OFS_CTRL, 32'h3);
            do @(posedge clk); while (txs !== 1'b1);
            @(negedge clk);
            tq.push_back(per(b, b[5:3], tf));
            do @(posedge clk); while (rxs !== 1'b1);
            @(negedge clk);
            pq.push_back(per(b, b[2:0], rf));
            while (tq.size() + pq.size() > 0) @(posedge clk);
            repeat (40) @(posedge clk);
        end
        bus(1'b1, OFS_CTRL, 32'h2);
        bus(1'b1, OFS_IRQ_EN, 32'h7);
        sbw_node_model_i.send(9'h0A5, 1'b0, 1);
        rd(OFS_IRQ_STAT, 32'h1);
        chk(32'h1, {31'h0, irq});
        bus(1'b1, OFS_IRQ_EN, 32'h0);
        chk(32'h0, {31'h0, irq});
        rd(OFS_RDATA, 32'h0A5);
        rd(OFS_IRQ_STAT, 32'h0);
        sbw_node_model_i.send(9'h000, 1'b1, 3);
        rd(OFS_IRQ_STAT, 32'h2);
        bus(1'b1, OFS_IRQ_CLR, 32'h7);
        bus(1'b1, OFS_CTRL, 32'h6);
        chk(32'h1, {31'h0, mute});
        sbw_node_model_i.send(9'h0FF, 1'b0, 1);
        sbw_node_model_i.send(9'h000, 1'b1, 20);
        rd(OFS_CTRL, 32'h2);
        chk(32'h0, {31'h0, mute});
        rd(OFS_IRQ_STAT, 32'h4);
        bus(1'b1, OFS_IRQ_CLR, 32'h7);
        bus(1'b1, OFS_CTRL, 32'hE);
        chk(32'h1, {31'h0, mute});
        sbw_node_model_i.send(9'h033, 1'b0, 1);
        sbw_node_model_i.send(9'h1C4, 1'b0, 5);
        rd(OFS_CTRL, 32'hA);
        chk(32'h0, {31'h0, mute});
        rd(OFS_IRQ_STAT, 32'h5);
        // Frozen for three edges: the read must wait, not complete
        ce <= 1'b0;
        fork
            rd(OFS_RDATA, 32'h1C4);
            begin
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        rd(OFS_IRQ_STAT, 32'h4);
        rd(OFS_IRQ_CLR, 32'h0);
        bus(1'b1, OFS_IRQ_CLR, 32'h7);
        rd(OFS_IRQ_STAT, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
